// *** uptr_defs.svh ***
// register offsets, field positions and reset values of the port trim bank
//
// Contract
// - Each status register shows the live main link state in bits 7:4.
// - Each status register shows the live link sub-state in bits 2:0.
// - Status bit 3 reads as a constant and ignores writes.
// - Each 3-bit transmit trim code is read/write and goes to its port.
// - Transmit trim bits 7:3 are stored and read back with no effect.
// - Each 3-bit squelch trim code is read/write and goes to its receiver.
// - Squelch trim bits 7:3 read as constant zero and ignore writes.
`ifndef UPTR_DEFS_SVH
`define UPTR_DEFS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define UPTR_IDX_W 17
`define UPTR_IDX_P1_SS_STATUS 17'h065C0
`define UPTR_IDX_P2_TX_TRIM 17'h068CA
`define UPTR_IDX_P2_SQ_TRIM 17'h068CC
`define UPTR_IDX_P2_SS_STATUS 17'h069C0
`define UPTR_IDX_P3_TX_TRIM 17'h06CCA
`define UPTR_IDX_P3_SQ_TRIM 17'h06CCC
`define UPTR_IDX_P3_SS_STATUS 17'h06DC0
`define UPTR_IDX_P4_TX_TRIM 17'h070CA

// ----------------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------------
`define UPTR_SS_RSVD_VAL 1'h0
`define UPTR_SQ_RSVD_VAL 5'h00
`define UPTR_TX_RST 8'h00
`define UPTR_SQ_RST 3'h0
`define UPTR_STEP_RST 4'h0

// ----------------------------------------------------------------------
// bus response codes
// ----------------------------------------------------------------------
`define UPTR_RESP_OKAY 2'h0
`define UPTR_RESP_DECERR 2'h3

`endif

// *** uptr_pkg.sv ***
// types and decode functions shared by the port trim bank
`include "uptr_defs.svh"

package uptr_pkg;

   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef logic [2:0] uptr_code_t;
   typedef logic [3:0] uptr_step_t;
   typedef enum {UPTR_WR_IDLE, UPTR_WR_RESP} uptr_wr_e;
   typedef enum {UPTR_RD_IDLE, UPTR_RD_RESP} uptr_rd_e;
   typedef enum {
      UPTR_REG_NONE, UPTR_REG_P1_STAT, UPTR_REG_P2_TX, UPTR_REG_P2_SQ,
      UPTR_REG_P2_STAT, UPTR_REG_P3_TX, UPTR_REG_P3_SQ, UPTR_REG_P3_STAT,
      UPTR_REG_P4_TX
   } uptr_reg_e;

   // ----------------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------------
   // byte address to register; upper address bits must be clear
   function automatic uptr_reg_e uptr_reg_sel(input logic [31:0] a);
      uptr_reg_sel = UPTR_REG_NONE;
      if (a[31:`UPTR_IDX_W+2] == '0) begin
         case (a[`UPTR_IDX_W+1:2])
            `UPTR_IDX_P1_SS_STATUS: uptr_reg_sel = UPTR_REG_P1_STAT;
            `UPTR_IDX_P2_TX_TRIM: uptr_reg_sel = UPTR_REG_P2_TX;
            `UPTR_IDX_P2_SQ_TRIM: uptr_reg_sel = UPTR_REG_P2_SQ;
            `UPTR_IDX_P2_SS_STATUS: uptr_reg_sel = UPTR_REG_P2_STAT;
            `UPTR_IDX_P3_TX_TRIM: uptr_reg_sel = UPTR_REG_P3_TX;
            `UPTR_IDX_P3_SQ_TRIM: uptr_reg_sel = UPTR_REG_P3_SQ;
            `UPTR_IDX_P3_SS_STATUS: uptr_reg_sel = UPTR_REG_P3_STAT;
            `UPTR_IDX_P4_TX_TRIM: uptr_reg_sel = UPTR_REG_P4_TX;
            default: uptr_reg_sel = UPTR_REG_NONE;
         endcase
      end
   endfunction

   // transmit code to signed step in units of 5 percent
   function automatic uptr_step_t uptr_tx_step(input uptr_code_t c);
      case (c)
         3'h0: uptr_tx_step = 4'h0;
         3'h1: uptr_tx_step = 4'hF;
         3'h2: uptr_tx_step = 4'h2;
         3'h3: uptr_tx_step = 4'h1;
         3'h4: uptr_tx_step = 4'h4;
         3'h5: uptr_tx_step = 4'h3;
         3'h6: uptr_tx_step = 4'h6;
         default: uptr_tx_step = 4'h5;
      endcase
   endfunction

   // squelch code to signed step in units of 12.5 mV off 100 mV
   function automatic uptr_step_t uptr_sq_step(input uptr_code_t c);
      case (c)
         3'h0: uptr_sq_step = 4'h0;
         3'h1: uptr_sq_step = 4'hF;
         3'h2: uptr_sq_step = 4'hE;
         3'h3: uptr_sq_step = 4'hD;
         3'h4: uptr_sq_step = 4'hC;
         3'h5: uptr_sq_step = 4'hB;
         3'h6: uptr_sq_step = 4'h2;
         default: uptr_sq_step = 4'h1;
      endcase
   endfunction

endpackage

// *** uptr_trim_if.sv ***
// code and decoded step passed from the register bank to a trim decoder
`timescale 1ns/100ps

interface uptr_trim_if;
   uptr_pkg::uptr_code_t code;
   uptr_pkg::uptr_step_t step;
   modport src (output code, input step);
   modport dec (input code, output step);
endinterface

// *** uptr_tx_trim_dec.sv ***
// registered decode of a transmit current trim code
`timescale 1ns/100ps
`include "uptr_defs.svh"

module uptr_tx_trim_dec (
   input wire logic aclk,
   input wire logic aresetn,
   uptr_trim_if.dec trim
);

   uptr_pkg::uptr_step_t step_ff;
   uptr_pkg::uptr_step_t nxt_step;

   // every port shares one table, port 4 included
   always_comb begin
      nxt_step = uptr_pkg::uptr_tx_step(trim.code);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_ff <= `UPTR_STEP_RST;
      end else begin
         step_ff <= nxt_step;
      end
   end

   assign trim.step = step_ff;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   code_101_dec_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (trim.code == 3'h5) |=> (trim.step == 4'h3))
      else $error("code 101 not decoded as +15 percent");
   code_110_dec_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (trim.code == 3'h6) |=> (trim.step == 4'h6))
      else $error("code 110 not decoded as +30 percent");

endmodule

// *** uptr_sq_trim_dec.sv ***
// registered decode of a squelch trim code
`timescale 1ns/100ps
`include "uptr_defs.svh"

module uptr_sq_trim_dec (
   input wire logic aclk,
   input wire logic aresetn,
   uptr_trim_if.dec trim
);

   uptr_pkg::uptr_step_t step_ff;
   uptr_pkg::uptr_step_t nxt_step;

   // 001..101 lower the trip point, 110 and 111 raise it
   always_comb begin
      nxt_step = uptr_pkg::uptr_sq_step(trim.code);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_ff <= `UPTR_STEP_RST;
      end else begin
         step_ff <= nxt_step;
      end
   end

   assign trim.step = step_ff;

   sq_raise_dec_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (trim.code == 3'h6) |=> (trim.step == 4'h2))
      else $error("squelch code 110 not decoded as +25 mV");

endmodule

// *** uptr_port_trim_regs.sv ***
// per-port link status and trim register bank behind an AXI4-Lite slave
`timescale 1ns/100ps
`include "uptr_defs.svh"

module uptr_port_trim_regs (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [2:0][3:0] ss_link_state,
   input wire logic [2:0][2:0] ss_link_sub_state,
   output logic [2:0][2:0] tx_current_trim_code,
   output logic [2:0][3:0] tx_current_step,
   output logic [1:0][2:0] squelch_trim_code,
   output logic [1:0][3:0] squelch_step
);

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   uptr_pkg::uptr_wr_e wr_st_ff, nxt_wr_st;
   uptr_pkg::uptr_rd_e rd_st_ff, nxt_rd_st;
   uptr_pkg::uptr_reg_e wr_sel, rd_sel;
   logic aw_got_ff, nxt_aw_got;
   logic [31:0] aw_addr_ff, nxt_aw_addr;
   logic w_got_ff, nxt_w_got;
   logic [7:0] w_data_ff, nxt_w_data;
   logic w_lane0_ff, nxt_w_lane0;
   logic [1:0] bresp_ff, nxt_bresp;
   logic [1:0] rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [7:0] rd_byte;
   logic wr_fire;
   logic [2:0][7:0] tx_trim_ff, nxt_tx_trim;
   logic [1:0][2:0] sq_trim_ff, nxt_sq_trim;

   // ----------------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------------
   // address and data are taken in either order; the write happens once
   // both are held, so a slow data phase never writes a stale address
   assign s_axi_awready = !aw_got_ff && (wr_st_ff == uptr_pkg::UPTR_WR_IDLE);
   assign s_axi_wready = !w_got_ff && (wr_st_ff == uptr_pkg::UPTR_WR_IDLE);
   assign s_axi_bvalid = (wr_st_ff == uptr_pkg::UPTR_WR_RESP);
   assign s_axi_bresp = bresp_ff;
   assign wr_fire = aw_got_ff && w_got_ff &&
      (wr_st_ff == uptr_pkg::UPTR_WR_IDLE);
   assign wr_sel = uptr_pkg::uptr_reg_sel(aw_addr_ff);

   // next values of the write channel
   always_comb begin
      nxt_wr_st = wr_st_ff;
      nxt_aw_got = aw_got_ff;
      nxt_aw_addr = aw_addr_ff;
      nxt_w_got = w_got_ff;
      nxt_w_data = w_data_ff;
      nxt_w_lane0 = w_lane0_ff;
      nxt_bresp = bresp_ff;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_aw_got = 1'b1;
         nxt_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_w_got = 1'b1;
         nxt_w_data = s_axi_wdata[7:0];
         nxt_w_lane0 = s_axi_wstrb[0];
      end
      case (wr_st_ff)
         uptr_pkg::UPTR_WR_IDLE: begin
            if (wr_fire) begin
               nxt_aw_got = 1'b0;
               nxt_w_got = 1'b0;
               nxt_wr_st = uptr_pkg::UPTR_WR_RESP;
               nxt_bresp = (wr_sel == uptr_pkg::UPTR_REG_NONE) ?
                  `UPTR_RESP_DECERR : `UPTR_RESP_OKAY;
            end
         end
         uptr_pkg::UPTR_WR_RESP: begin
            if (s_axi_bready) begin
               nxt_wr_st = uptr_pkg::UPTR_WR_IDLE;
            end
         end
         default: nxt_wr_st = uptr_pkg::UPTR_WR_IDLE;
      endcase
   end

   // register the write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_st_ff <= uptr_pkg::UPTR_WR_IDLE;
         aw_got_ff <= 1'b0;
         aw_addr_ff <= 32'h0000_0000;
         w_got_ff <= 1'b0;
         w_data_ff <= 8'h00;
         w_lane0_ff <= 1'b0;
         bresp_ff <= `UPTR_RESP_OKAY;
      end else begin
         wr_st_ff <= nxt_wr_st;
         aw_got_ff <= nxt_aw_got;
         aw_addr_ff <= nxt_aw_addr;
         w_got_ff <= nxt_w_got;
         w_data_ff <= nxt_w_data;
         w_lane0_ff <= nxt_w_lane0;
         bresp_ff <= nxt_bresp;
      end
   end

   // ----------------------------------------------------------------------
   // trim registers
   // ----------------------------------------------------------------------
   // only byte lane 0 holds data; status registers take no write at all
   always_comb begin
      nxt_tx_trim = tx_trim_ff;
      nxt_sq_trim = sq_trim_ff;
      if (wr_fire && w_lane0_ff) begin
         case (wr_sel)
            uptr_pkg::UPTR_REG_P2_TX: nxt_tx_trim[0] = w_data_ff;
            uptr_pkg::UPTR_REG_P3_TX: nxt_tx_trim[1] = w_data_ff;
            uptr_pkg::UPTR_REG_P4_TX: nxt_tx_trim[2] = w_data_ff;
            uptr_pkg::UPTR_REG_P2_SQ: nxt_sq_trim[0] = w_data_ff[2:0];
            uptr_pkg::UPTR_REG_P3_SQ: nxt_sq_trim[1] = w_data_ff[2:0];
            default: nxt_tx_trim = tx_trim_ff;
         endcase
      end
   end

   // trim codes come up nominal, since the transmitter must start sane
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_trim_ff <= {3{`UPTR_TX_RST}};
         sq_trim_ff <= {2{`UPTR_SQ_RST}};
      end else begin
         tx_trim_ff <= nxt_tx_trim;
         sq_trim_ff <= nxt_sq_trim;
      end
   end

   // ----------------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------------
   // handshake straight from the state register, so one read at a time
   assign s_axi_arready = (rd_st_ff == uptr_pkg::UPTR_RD_IDLE);
   assign s_axi_rvalid = (rd_st_ff == uptr_pkg::UPTR_RD_RESP);
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign rd_sel = uptr_pkg::uptr_reg_sel(s_axi_araddr);

   // status is sampled live at the address edge, not held in a copy
   always_comb begin
      case (rd_sel)
         uptr_pkg::UPTR_REG_P1_STAT: rd_byte = {ss_link_state[0],
            `UPTR_SS_RSVD_VAL, ss_link_sub_state[0]};
         uptr_pkg::UPTR_REG_P2_STAT: rd_byte = {ss_link_state[1],
            `UPTR_SS_RSVD_VAL, ss_link_sub_state[1]};
         uptr_pkg::UPTR_REG_P3_STAT: rd_byte = {ss_link_state[2],
            `UPTR_SS_RSVD_VAL, ss_link_sub_state[2]};
         uptr_pkg::UPTR_REG_P2_TX: rd_byte = tx_trim_ff[0];
         uptr_pkg::UPTR_REG_P3_TX: rd_byte = tx_trim_ff[1];
         uptr_pkg::UPTR_REG_P4_TX: rd_byte = tx_trim_ff[2];
         uptr_pkg::UPTR_REG_P2_SQ: rd_byte = {`UPTR_SQ_RSVD_VAL,
            sq_trim_ff[0]};
         uptr_pkg::UPTR_REG_P3_SQ: rd_byte = {`UPTR_SQ_RSVD_VAL,
            sq_trim_ff[1]};
         default: rd_byte = 8'h00;
      endcase
   end

   // next values of the read channel
   always_comb begin
      nxt_rd_st = rd_st_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      case (rd_st_ff)
         uptr_pkg::UPTR_RD_IDLE: begin
            if (s_axi_arvalid) begin
               nxt_rd_st = uptr_pkg::UPTR_RD_RESP;
               nxt_rdata = {24'h00_0000, rd_byte};
               nxt_rresp = (rd_sel == uptr_pkg::UPTR_REG_NONE) ?
                  `UPTR_RESP_DECERR : `UPTR_RESP_OKAY;
            end
         end
         uptr_pkg::UPTR_RD_RESP: begin
            if (s_axi_rready) begin
               nxt_rd_st = uptr_pkg::UPTR_RD_IDLE;
            end
         end
         default: nxt_rd_st = uptr_pkg::UPTR_RD_IDLE;
      endcase
   end

   // register the read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_st_ff <= uptr_pkg::UPTR_RD_IDLE;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= `UPTR_RESP_OKAY;
      end else begin
         rd_st_ff <= nxt_rd_st;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   // ----------------------------------------------------------------------
   // decoders for transmitter and receiver
   // ----------------------------------------------------------------------
   // one decoder per trim register; the step trails the code by one cycle
   for (genvar i = 0; i < 3; i++) begin : g_tx
      uptr_trim_if tx_if ();
      assign tx_if.code = tx_trim_ff[i][2:0];
      assign tx_current_trim_code[i] = tx_trim_ff[i][2:0];
      assign tx_current_step[i] = tx_if.step;
      uptr_tx_trim_dec u_dec (
         .aclk(aclk),
         .aresetn(aresetn),
         .trim(tx_if.dec)
      );
   end

   for (genvar j = 0; j < 2; j++) begin : g_sq
      uptr_trim_if sq_if ();
      assign sq_if.code = sq_trim_ff[j];
      assign squelch_trim_code[j] = sq_trim_ff[j];
      assign squelch_step[j] = sq_if.step;
      uptr_sq_trim_dec u_dec (
         .aclk(aclk),
         .aresetn(aresetn),
         .trim(sq_if.dec)
      );
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   // bus side: each property looks one cycle past the taking edge; tx_code_wr_a checks the step one cycle later still
   link_state_rd_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && rd_sel == uptr_pkg::UPTR_REG_P1_STAT)
      |=> (s_axi_rvalid && s_axi_rdata[7:4] == $past(ss_link_state[0])))
      else $error("port 1 link state not returned");
   sub_state_rd_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && rd_sel == uptr_pkg::UPTR_REG_P2_STAT)
      |=> (s_axi_rdata[2:0] == $past(ss_link_sub_state[1])))
      else $error("port 2 sub-state not returned");
   status_rsvd_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && rd_sel == uptr_pkg::UPTR_REG_P3_STAT)
      |=> (s_axi_rdata[3] == 1'b0 && s_axi_rdata[31:8] == 24'h00_0000))
      else $error("status reserved bit not constant");
   tx_code_wr_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (wr_fire && w_lane0_ff && wr_sel == uptr_pkg::UPTR_REG_P2_TX)
      |=> (tx_current_trim_code[0] == $past(w_data_ff[2:0]))
      ##1 (tx_current_step[0] ==
      uptr_pkg::uptr_tx_step($past(w_data_ff[2:0], 2))))
      else $error("port 2 transmit trim not applied");
   tx_rsvd_keep_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && rd_sel == uptr_pkg::UPTR_REG_P3_TX)
      |=> (s_axi_rdata[7:0] == $past(tx_trim_ff[1])))
      else $error("port 3 transmit trim readback wrong");
   sq_code_wr_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (wr_fire && w_lane0_ff && wr_sel == uptr_pkg::UPTR_REG_P3_SQ)
      |=> (squelch_trim_code[1] == $past(w_data_ff[2:0])))
      else $error("port 3 squelch trim not applied");
   sq_rsvd_zero_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && rd_sel == uptr_pkg::UPTR_REG_P2_SQ)
      |=> (s_axi_rdata[7:3] == 5'h00))
      else $error("squelch reserved bits not zero");
   reset_nominal_a: assert property (@(posedge aclk)
      !aresetn |=> (tx_current_trim_code == 9'h000 &&
      squelch_trim_code == 6'h00 && !s_axi_bvalid && !s_axi_rvalid))
      else $error("trim not nominal after reset");
   write_resp_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid)
      else $error("write response missing");
   status_no_wr_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (wr_fire && wr_sel == uptr_pkg::UPTR_REG_P1_STAT)
      |=> ($stable(tx_trim_ff) && $stable(sq_trim_ff)))
      else $error("status write changed a trim register");

endmodule

// *** test_uptr_port_trim_regs.sv ***
// self-checking testbench of the port trim register bank
`timescale 1ns/100ps
`include "uptr_defs.svh"

module test_uptr_port_trim_regs;
   // ----------------------------------------------------------------
   // types, constants and signals
   // ----------------------------------------------------------------
   typedef struct {
      logic [31:0] addr;
      logic [7:0] wd;
      logic [3:0] strb;
      logic [1:0] wr;
      logic [7:0] rd;
      logic [1:0] rr;
   } uptr_row_s;
   localparam logic [1:0] ok = 2'h0;
   localparam logic [1:0] de = 2'h3;
   localparam logic [31:0] a_p1_st = {13'h0000, `UPTR_IDX_P1_SS_STATUS, 2'h0};
   localparam logic [31:0] a_p2_tx = {13'h0000, `UPTR_IDX_P2_TX_TRIM, 2'h0};
   localparam logic [31:0] a_p2_sq = {13'h0000, `UPTR_IDX_P2_SQ_TRIM, 2'h0};
   localparam logic [31:0] a_p2_st = {13'h0000, `UPTR_IDX_P2_SS_STATUS, 2'h0};
   localparam logic [31:0] a_p3_tx = {13'h0000, `UPTR_IDX_P3_TX_TRIM, 2'h0};
   localparam logic [31:0] a_p3_sq = {13'h0000, `UPTR_IDX_P3_SQ_TRIM, 2'h0};
   localparam logic [31:0] a_p3_st = {13'h0000, `UPTR_IDX_P3_SS_STATUS, 2'h0};
   localparam logic [31:0] a_p4_tx = {13'h0000, `UPTR_IDX_P4_TX_TRIM, 2'h0};
   logic [31:0] tx_addr [3] = '{a_p2_tx, a_p3_tx, a_p4_tx};
   logic [31:0] sq_addr [2] = '{a_p2_sq, a_p3_sq};
   logic [31:0] st_addr [3] = '{a_p1_st, a_p2_st, a_p3_st};
   // expected signed steps, worked out from the code tables
   logic [3:0] tx_tab [8] = '{4'h0, 4'hF, 4'h2, 4'h1, 4'h4, 4'h3, 4'h6, 4'h5};
   logic [3:0] sq_tab [8] = '{4'h0, 4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'h2, 4'h1};
   uptr_row_s rows [11];
   int errors = 0;
   int comparisons = 0;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0][3:0] ss_link_state, tx_current_step;
   logic [2:0][2:0] ss_link_sub_state, tx_current_trim_code;
   logic [1:0][2:0] squelch_trim_code;
   logic [1:0][3:0] squelch_step;

   uptr_port_trim_regs u_uptr_port_trim_regs (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .ss_link_state, .ss_link_sub_state,
      .tx_current_trim_code, .tx_current_step, .squelch_trim_code,
      .squelch_step
   );

   // ----------------------------------------------------------------
   // clock, compare and bus tasks
   // ----------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic fault(input string m);
      errors++;
      $display("wrong value at %0t: %s", $time, m);
   endtask

   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) fault($sformatf("data %h, want %h", got, exp));
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      comparisons++;
      if (got !== exp) fault($sformatf("resp %h, want %h", got, exp));
   endtask

   task automatic chk_out(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp) fault($sformatf("output %h, want %h", got, exp));
   endtask

   // offers address and data together, drops each once it is taken
   task automatic axi_write(input logic [31:0] a, input logic [7:0] d,
         input logic [3:0] s, output logic [1:0] r);
      int n;
      n = 0;
      r = 2'h2;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (n < 50) begin
         @(posedge aclk);
         n++;
         if (s_axi_bvalid === 1'b1) break;
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      r = s_axi_bresp;
      if (n >= 50) fault("write never answered");
   endtask

   // idles 'stall' cycles first; raises rready and never drops it, even after rvalid is seen
   task automatic axi_read(input logic [31:0] a, input int stall,
         output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      repeat (stall) @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (n < 50) begin
         @(posedge aclk);
         n++;
         if (s_axi_rvalid === 1'b1) break;
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (n >= 50) fault("read never answered");
   endtask

   task automatic results;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // watchdog: the whole run needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge aclk);
      fault("run timed out");
      results();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [3:0] st;
      rows[0] = '{a_p2_tx, 8'hFB, 4'hF, ok, 8'hFB, ok};
      rows[1] = '{a_p2_tx, 8'hFF, 4'h0, ok, 8'hFB, ok};
      rows[2] = '{a_p2_sq, 8'hFE, 4'hF, ok, 8'h06, ok};
      rows[3] = '{a_p3_tx, 8'hA5, 4'hF, ok, 8'hA5, ok};
      rows[4] = '{a_p3_sq, 8'hF9, 4'h1, ok, 8'h01, ok};
      rows[5] = '{a_p4_tx, 8'h5E, 4'h1, ok, 8'h5E, ok};
      rows[6] = '{a_p1_st, 8'hFF, 4'hF, ok, 8'hA5, ok};
      rows[7] = '{a_p2_st, 8'h08, 4'hF, ok, 8'h52, ok};
      rows[8] = '{a_p3_st, 8'hFF, 4'hF, ok, 8'hF7, ok};
      rows[9] = '{a_p1_st + 32'h00000004, 8'h55, 4'hF, de, 8'h00, de};
      rows[10] = '{a_p1_st | 32'h00080000, 8'h55, 4'hF, de, 8'h00, de};
      aresetn = 1'b0;
      s_axi_awaddr = 32'h00000000;
      s_axi_wdata = 32'h00000000;
      s_axi_araddr = 32'h00000000;
      s_axi_wstrb = 4'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b0;
      ss_link_state = {4'hF, 4'h5, 4'hA};
      ss_link_sub_state = {3'h7, 3'h2, 3'h5};
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // transmit trims come out of reset nominal
      for (int p = 0; p < 3; p++) begin
         chk_out({1'b0, tx_current_trim_code[p]}, 4'h0);
      end
      axi_read(a_p4_tx, 0, d, r);
      chk_data(d, 32'h00000000);
      // table rows: write, then read back through the bus
      foreach (rows[i]) begin
         axi_write(rows[i].addr, rows[i].wd, rows[i].strb, r);
         chk_resp(r, rows[i].wr);
         axi_read(rows[i].addr, i % 3, d, r);
         chk_data(d, {24'h000000, rows[i].rd});
         chk_resp(r, rows[i].rr);
      end
      // status follows the live link inputs, bit 3 stays clear
      for (int i = 0; i < 16; i++) begin
         st = i[3:0];
         ss_link_state <= {st, ~st, st ^ 4'h9};
         ss_link_sub_state <= {st[2:0], ~st[2:0], st[2:0] ^ 3'h5};
         for (int p = 0; p < 3; p++) begin
            axi_read(st_addr[p], i % 4, d, r);
            chk_data(d, {24'h0, ss_link_state[p], 1'b0,
               ss_link_sub_state[p]});
         end
      end
      // every code on every port reaches the code and step outputs
      for (int c = 0; c < 8; c++) begin
         for (int p = 0; p < 3; p++) axi_write(tx_addr[p], c[7:0], 4'h1, r);
         for (int p = 0; p < 2; p++) begin
            axi_write(sq_addr[p], {5'h1F, c[2:0]}, 4'h1, r);
         end
         repeat (2) @(posedge aclk);
         for (int p = 0; p < 3; p++) begin
            chk_out({1'b0, tx_current_trim_code[p]}, {1'b0, c[2:0]});
            chk_out(tx_current_step[p], tx_tab[c]);
         end
         for (int p = 0; p < 2; p++) begin
            chk_out({1'b0, squelch_trim_code[p]}, {1'b0, c[2:0]});
            chk_out(squelch_step[p], sq_tab[c]);
         end
      end
      // second reset in mid-run brings every transmit trim and the port 3 squelch trim back to nominal
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      for (int p = 0; p < 3; p++) begin
         chk_out({1'b0, tx_current_trim_code[p]}, 4'h0);
      end
      chk_out({1'b0, squelch_trim_code[1]}, 4'h0);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_read(a_p3_sq, 1, d, r);
      chk_data(d, 32'h00000000);
      results();
   end
endmodule
